// [design/sram_consts.svh]
// widths and burst constants of the synchronous flow-through sram
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH
`define ADDR_W     17
`define DATA_W     36
`define LANES      4
`define LANE_W     8
`define PAR_BASE   32
`define BURST_W    2
`define WORDS      131072
`endif

// [design/sram_pkg.sv]
// types shared by the sram pin control logic
`include "sram_consts.svh"
package sram_pkg;
    // control stage: registered address, command and burst position
    typedef struct packed {
        logic                  active;  // a data cycle follows
        logic                  write;   // write burst when high
        logic [`ADDR_W-1:0]    addr;    // address loaded at start of burst
        logic [`BURST_W-1:0]   cnt;     // beats advanced since load
        logic [`LANES-1:0]     laneWr;  // byte lanes to write, high active
    } ctl_t;
    // write stage: captured write data waiting for the array
    typedef struct packed {
        logic                  pend;
        logic [`ADDR_W-1:0]    addr;
        logic [`DATA_W-1:0]    data;
        logic [`LANES-1:0]     laneWr;
    } wr_t;
endpackage

// [design/sync_sram_pin_control.sv]
// pin-level control and array of a synchronous flow-through sram
`timescale 1ns/10ps
`include "sram_consts.svh"
module sync_sram_pin_control
    import sram_pkg::*;
(
    input  wire logic                clk,              // 125 MHz clock
    input  wire logic                rst_n,            // synchronous reset, low
    input  wire logic [`ADDR_W-1:0]  addr,             // address pins
    input  wire logic                readNotWrite,     // high read, low write
    input  wire logic                load_or_advance,  // low load, high advance
    input  wire logic                clock_enable_low, // low lets the edge act
    input  wire logic [`LANES-1:0]   byteWriteLow,     // per-lane write, low
    input  wire logic                first_low_select, // chip select, low
    input  wire logic                secondLowSelect,  // chip select, low
    input  wire logic                active_high_select, // chip select, high
    input  wire logic                burst_order_pin,  // high interleaved
    input  wire logic                outputEnableLow,  // asynchronous, low
    input  wire logic [`DATA_W-1:0]  dataIn,           // data pin input
    output logic      [`DATA_W-1:0]  dataOut,          // data pin output
    output logic                     dataOe            // data pin drive enable
);
    ctl_t                ctl_r, ctl_nxt;
    wr_t                 wr_r, wr_nxt;
    logic                burstOrder_r, burstOrder_nxt;
    logic [`DATA_W-1:0]  mem [`WORDS];
    logic                edgeOn;
    logic                selected;
    logic [`ADDR_W-1:0]  curAddr;
    logic [`BURST_W-1:0] beat;
    logic [`DATA_W-1:0]  arrayWord;
    logic [`DATA_W-1:0]  mergedWord;
    logic [`DATA_W-1:0]  readWord;

    // command decode; controller shares this clock so no synchroniser
    assign edgeOn   = ~clock_enable_low;
    assign selected = ~first_low_select & ~secondLowSelect & active_high_select;

    // burst address: low two bits stepped, upper bits from the load
    always_comb begin
        if (burstOrder_r) begin
            beat = ctl_r.addr[`BURST_W-1:0] ^ ctl_r.cnt;
        end else begin
            beat = ctl_r.addr[`BURST_W-1:0] + ctl_r.cnt;
        end
        curAddr = {ctl_r.addr[`ADDR_W-1:`BURST_W], beat};
    end

    // control stage next values
    always_comb begin
        ctl_nxt        = ctl_r;
        burstOrder_nxt = burstOrder_r;
        if (edgeOn) begin
            burstOrder_nxt = burst_order_pin;
            ctl_nxt.laneWr = ~byteWriteLow;
            if (!load_or_advance) begin
                if (selected) begin
                    ctl_nxt.active = 1'b1;
                    ctl_nxt.write  = ~readNotWrite;
                    ctl_nxt.addr   = addr;
                    ctl_nxt.cnt    = '0;
                end else begin
                    ctl_nxt.active = 1'b0;
                end
            end else if (ctl_r.active) begin
                // external address ignored; pending burst keeps its direction
                ctl_nxt.cnt = ctl_r.cnt + 1'b1;
            end
        end
        if (!rst_n) begin
            ctl_nxt        = '0;
            burstOrder_nxt = 1'b0;
        end
    end

    // write stage next values: data pins sampled one edge after control
    always_comb begin
        wr_nxt = wr_r;
        if (edgeOn) begin
            wr_nxt.pend   = ctl_r.active & ctl_r.write & (|ctl_r.laneWr);
            wr_nxt.addr   = curAddr;
            wr_nxt.data   = dataIn;
            wr_nxt.laneWr = ctl_r.laneWr;
        end
        if (!rst_n) begin
            wr_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        ctl_r        <= ctl_nxt;
        wr_r         <= wr_nxt;
        burstOrder_r <= burstOrder_nxt;
    end

    // array write from the input register; frozen while suspended
    always_ff @(posedge clk) begin
        if (edgeOn && wr_r.pend) begin
            mem[wr_r.addr] <= mergedWord;
        end
    end

    // per-lane merge of captured data over the stored word
    assign arrayWord = mem[wr_r.addr];
    for (genvar k = 0; k < `LANES; k++) begin : gLane
        assign mergedWord[k*`LANE_W +: `LANE_W] = wr_r.laneWr[k] ?
            wr_r.data[k*`LANE_W +: `LANE_W] : arrayWord[k*`LANE_W +: `LANE_W];
        assign mergedWord[`PAR_BASE+k] = wr_r.laneWr[k] ?
            wr_r.data[`PAR_BASE+k] : arrayWord[`PAR_BASE+k];
    end

    // read path bypasses a write still in the input register, so a
    // read right after a write to the same word sees the new data
    assign readWord = (wr_r.pend && wr_r.addr == curAddr) ? mergedWord : mem[curAddr];

    // flow-through output: no register, so these two cannot come from
    // flip-flops; enable also honours the asynchronous output enable
    assign dataOut = readWord;
    assign dataOe  = ctl_r.active & ~ctl_r.write & ~outputEnableLow;

    // ------------------------------------------------------------ checks
    property p_select;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && !load_or_advance && selected) |=> ctl_r.active;
    endproperty
    a_select: assert property (p_select) else $error("load not accepted");

    property p_deselect;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && !load_or_advance && !selected) |=> !dataOe;
    endproperty
    a_deselect: assert property (p_deselect) else $error("bus driven after deselect");

    property p_suspend;
        @(posedge clk) disable iff (!rst_n)
        (!edgeOn) |=> ($stable(ctl_r) && $stable(wr_r));
    endproperty
    a_suspend: assert property (p_suspend) else $error("state moved while suspended");

    property p_readCycle;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && !load_or_advance && selected && readNotWrite)
            |=> (dataOe || outputEnableLow);
    endproperty
    a_readCycle: assert property (p_readCycle) else $error("read data cycle late");

    property p_oeFloat;
        @(posedge clk) disable iff (!rst_n)
        outputEnableLow |-> !dataOe;
    endproperty
    a_oeFloat: assert property (p_oeFloat) else $error("pins driven with oe high");

    property p_driveOnlyRead;
        @(posedge clk) disable iff (!rst_n)
        dataOe |-> (ctl_r.active && !ctl_r.write);
    endproperty
    a_driveOnlyRead: assert property (p_driveOnlyRead) else $error("drive outside read");

    property p_captureData;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && ctl_r.active && ctl_r.write && |ctl_r.laneWr)
            |=> (wr_r.pend && wr_r.data == $past(dataIn));
    endproperty
    a_captureData: assert property (p_captureData) else $error("write data not captured");

    property p_advance;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && load_or_advance && ctl_r.active)
            |=> (ctl_r.cnt == $past(ctl_r.cnt) + 2'h1 && $stable(ctl_r.addr));
    endproperty
    a_advance: assert property (p_advance) else $error("burst counter not stepped");

    property p_loadAddr;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && !load_or_advance && selected)
            |=> (ctl_r.addr == $past(addr) && ctl_r.cnt == 2'h0);
    endproperty
    a_loadAddr: assert property (p_loadAddr) else $error("load address lost");

    // linear order steps the low address bits by one per advance
    property p_linearStep;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && load_or_advance && ctl_r.active && !burstOrder_r)
            |=> (curAddr[1:0] == $past(curAddr[1:0]) + 2'h1);
    endproperty
    a_linearStep: assert property (p_linearStep) else $error("linear step wrong");

    // no disable here: this one watches the reset itself
    property p_resetIdle;
        @(posedge clk)
        !rst_n |=> (!ctl_r.active && !wr_r.pend && !dataOe);
    endproperty
    a_resetIdle: assert property (p_resetIdle) else $error("busy after reset");

    property p_coverRead;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && !load_or_advance && selected && readNotWrite) ##1 dataOe;
    endproperty
    c_coverRead: cover property (p_coverRead);

    property p_coverWrite;
        @(posedge clk) disable iff (!rst_n)
        (edgeOn && !load_or_advance && selected && !readNotWrite) ##2 wr_r.pend;
    endproperty
    c_coverWrite: cover property (p_coverWrite);

    property p_coverBurst;
        @(posedge clk) disable iff (!rst_n)
        (ctl_r.active && ctl_r.cnt == 2'h3 && dataOe);
    endproperty
    c_coverBurst: cover property (p_coverBurst);

    property p_coverFloat;
        @(posedge clk) disable iff (!rst_n)
        (ctl_r.active && !ctl_r.write && outputEnableLow);
    endproperty
    c_coverFloat: cover property (p_coverFloat);
endmodule

// [testbench/mem_ctl_model.sv]
// memory controller model driving the sram pins
`timescale 1ns/10ps
`include "sram_consts.svh"
module mem_ctl_model
    import sram_pkg::*;
(
    input  wire logic clk  // shared clock
);
    logic [`ADDR_W-1:0] addr   = 17'h00000;
    logic               rnw    = 1'b1;
    logic               ldAdv  = 1'b1;
    logic               cenLow = 1'b1;
    logic [2:0]         sel    = 3'h6;   // {first low, second low, high}
    logic [`LANES-1:0]  bwLow  = 4'hF;
    logic [`DATA_W-1:0] din    = 36'h0;
    logic               order  = 1'b0;   // strap, changed only in reset
    logic               oeLow  = 1'b0;   // tied low, raised only by a float
    // control for the coming edge, data for the write beat before it
    task automatic beat(input logic ld, wr, ce, input logic [2:0] s,
        input logic [`ADDR_W-1:0] a, input logic [`LANES-1:0] bw,
        input logic dv, input logic [`DATA_W-1:0] d);
        @(posedge clk);
        ldAdv  <= ~ld;
        rnw    <= ~wr;
        cenLow <= ~ce;
        sel    <= s;
        addr   <= a;
        bwLow  <= bw;
        din    <= dv ? d : ~din;  // data one cycle after its beat
        oeLow  <= 1'b0;           // a float lasts only until the next edge
    endtask
endmodule

// [testbench/sync_sram_pin_control_tb.sv]
// self-checking bench for the sram pin control block
`timescale 1ns/10ps
`include "sram_consts.svh"
module sync_sram_pin_control_tb;
    import sram_pkg::*;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic [`DATA_W-1:0] dataOut, pins, refMem[32];
    logic               dataOe, act, wr, expOe, pw, flt;
    logic [`ADDR_W-1:0] base, ea, pa;
    logic [1:0]         cnt;
    logic [3:0]         pbw;
    logic [31:0]        seed = 32'h4A6F;
    int                 n_fail = 0;
    int                 cmp_count = 0;
    mem_ctl_model ctl (.clk(clk));
    // pin level from both drivers
    assign pins = dataOe ? dataOut : ctl.din;
    sync_sram_pin_control dut (.clk(clk), .rst_n(rst_n), .addr(ctl.addr),
        .readNotWrite(ctl.rnw), .load_or_advance(ctl.ldAdv),
        .clock_enable_low(ctl.cenLow), .byteWriteLow(ctl.bwLow),
        .first_low_select(ctl.sel[2]), .secondLowSelect(ctl.sel[1]),
        .active_high_select(ctl.sel[0]), .burst_order_pin(ctl.order),
        .outputEnableLow(ctl.oeLow), .dataIn(pins), .dataOut(dataOut), .dataOe(dataOe));
    initial begin
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // burst position: xor when interleaved, add when linear
    function automatic logic [`ADDR_W-1:0] beatAddr(input logic [`ADDR_W-1:0] b,
        input logic [1:0] c, input logic il);
        return il ? {b[16:2], b[1:0] ^ c} : {b[16:2], b[1:0] + c};
    endfunction
    function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] o, n,
        input logic [`LANES-1:0] bw);
        for (int k = 0; k < `LANES; k++) begin
            if (!bw[k]) begin
                o[k*`LANE_W +: `LANE_W] = n[k*`LANE_W +: `LANE_W];
                o[`PAR_BASE+k] = n[`PAR_BASE+k];
            end
        end
        return o;
    endfunction
    task automatic compare(input string what, input logic [`DATA_W-1:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one cycle: drive, check the previous beat, then predict this one
    task automatic step(input logic ld, w, ce, input logic [2:0] s,
        input logic [`ADDR_W-1:0] a, input logic [`LANES-1:0] bw);
        logic [`DATA_W-1:0] d;
        seed = xs(seed);
        d = {seed[7:4], seed};
        ctl.beat(ld, w, ce, s, a, bw, pw & ce, d);
        #1;
        compare("dataOe", {35'h0, expOe}, {35'h0, dataOe});
        if (expOe) compare("dataOut", refMem[ea[4:0]], dataOut);
        // float while read data stands, held up to the next edge
        if (expOe && flt) begin
            ctl.oeLow = 1'b1;
            #1;
            compare("dataOe float", 36'h0, {35'h0, dataOe});
        end
        if (ce) begin
            if (pw) refMem[pa[4:0]] = merge(refMem[pa[4:0]], d, pbw);
            pw = 1'b0;
            if (ld) begin
                act = (s == 3'h1);  // all three selects must agree
                wr = w;
                base = a;
                cnt = 2'h0;
            end else if (act) begin
                cnt = cnt + 2'h1;
            end
            ea = beatAddr(base, cnt, ctl.order);
            pw = act & wr;
            pa = ea;
            pbw = bw;
            expOe = act & ~wr;
        end
    endtask
    initial begin
        #(8*6000);
        n_fail++;
        summarize();
    end
    initial begin
        logic [31:0] r;
        for (int ph = 0; ph < 2; ph++) begin
            // park on a deselect so no stale command acts after release
            ctl.beat(1'b1, 1'b0, 1'b1, 3'h0, 17'h00000, 4'hF, 1'b0, 36'h0);
            rst_n <= 1'b0;
            ctl.order <= ph[0];
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            {act, pw, expOe, wr, flt} = 5'h0;
            // write then read each of the 32 modelled words back to back
            for (int i = 0; i < 32; i++) begin
                step(1'b1, 1'b1, 1'b1, 3'h1, i[16:0], 4'h0);
                step(1'b1, 1'b0, 1'b1, 3'h1, i[16:0], 4'h0);
            end
            for (int i = 0; i < 400; i++) begin
                seed = xs(seed);
                r = seed;
                flt = r[31];
                step((r[2:0] < 3) || (r[2:0] == 5), r[3], r[2:0] != 6,
                    (r[2:0] == 5) ? ((r[6:4] == 3'h1) ? 3'h0 : r[6:4]) : 3'h1,
                    {12'h000, r[12:8]}, r[19:16]);
            end
        end
        summarize();
    end
endmodule
